/* File: inc/cbs_pkg.sv */
/*
 * Constants and carrier types for the core bank and flag register block.
 * Assumes an 8-bit core whose special function area sits at the bottom of
 * every data memory bank.
 */
`default_nettype none
package cbs_pkg;
    localparam int DW = 8;
    localparam int BW = 2;
    localparam int PW = 16;
    localparam int NIB = 4;

    // Special function area and register offsets
    localparam logic [7:0] SFR_END = 8'h60;
    localparam logic [7:0] A_BANK  = 8'h04;
    localparam logic [7:0] A_WORK  = 8'h05;
    localparam logic [7:0] A_JUMP  = 8'h06;
    localparam logic [7:0] A_LPL   = 8'h07;
    localparam logic [7:0] A_LRH   = 8'h08;
    localparam logic [7:0] A_LPH   = 8'h09;
    localparam logic [7:0] A_FLAGS = 8'h0A;

    // Flag byte layout
    localparam int F_WDT = 5;
    localparam int F_SLP = 4;
    localparam int F_SGN = 3;
    localparam int F_NUL = 2;
    localparam int F_NIB = 1;
    localparam int F_CRY = 0;

    localparam logic [1:0] BANK_RST  = 2'h0;
    localparam logic [1:0] BANK_RSVD = 2'h3;
    localparam logic [7:0] ZERO8     = 8'h00;

    typedef enum logic [7:0] {
        ALU_ADD  = 8'h01,
        ALU_SUB  = 8'h02,
        ALU_AND  = 8'h04,
        ALU_OR   = 8'h08,
        ALU_XOR  = 8'h10,
        ALU_RLC  = 8'h20,
        ALU_RRC  = 8'h40,
        ALU_PASS = 8'h80
    } cbs_op_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_DUMMY = 4'h2,
        ST_PREQ  = 4'h4,
        ST_PCAP  = 4'h8
    } cbs_state_t;

    typedef struct packed {
        logic       req;
        logic       we;
        logic       ind;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cbs_dreq_t;

    typedef struct packed {
        logic       go;
        logic       wr_work;
        cbs_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
    } cbs_alu_req_t;

    typedef struct packed {
        logic sgn;
        logic nul;
        logic nib;
        logic cry;
    } cbs_flags_t;
endpackage
`default_nettype wire

/* File: logic/cbs_alu.sv */
/*
 * Result and flag computation for one ALU operation.
 * Assumes the operands are stable for the cycle; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module cbs_alu
    import cbs_pkg::*;
(
    input  wire cbs_alu_req_t req,
    input  wire logic         carry_in,
    output logic [7:0]        result,
    output cbs_flags_t        flags,
    output cbs_flags_t        upd
);
    logic [7:0] bb;
    logic       ci;
    logic [8:0] s9;
    logic [4:0] s5;
    logic [7:0] s8;

    always_comb begin
        // Subtraction as a + ~b + 1 so carry means no borrow
        ci = (req.op == ALU_SUB);
        bb = ci ? ~req.b : req.b;
        s9 = {1'b0, req.a} + {1'b0, bb} + 9'(ci);
        s5 = {1'b0, req.a[NIB-1:0]} + {1'b0, bb[NIB-1:0]} + 5'(ci);
        s8 = {1'b0, req.a[DW-2:0]} + {1'b0, bb[DW-2:0]} + 8'(ci);
        result = ZERO8;
        flags = '0;
        upd = '0;
        unique case (req.op)
            ALU_ADD, ALU_SUB: begin
                result = s9[DW-1:0];
                flags.cry = s9[DW];
                flags.nib = s5[NIB];
                flags.sgn = s8[DW-1] ^ s9[DW];
                upd = '1;
            end
            ALU_AND: begin
                result = req.a & req.b;
                upd.nul = 1'b1;
            end
            ALU_OR: begin
                result = req.a | req.b;
                upd.nul = 1'b1;
            end
            ALU_XOR: begin
                result = req.a ^ req.b;
                upd.nul = 1'b1;
            end
            ALU_RLC: begin
                result = {req.a[DW-2:0], carry_in};
                flags.cry = req.a[DW-1];
                upd.cry = 1'b1;
            end
            ALU_RRC: begin
                result = {carry_in, req.a[DW-1:1]};
                flags.cry = req.a[0];
                upd.cry = 1'b1;
            end
            ALU_PASS: begin
                result = req.a;
            end
            // Idle request carries no operation code
            default: begin
                result = ZERO8;
            end
        endcase
        flags.nul = (result == ZERO8);
    end
endmodule
`default_nettype wire

/* File: logic/cbs_core_regs.sv */
/*
 * Core bank select, working register, jump low byte, lookup table and
 * flag registers, with data memory routing by bank.
 * Assumes one data access per cycle from the execution unit, a data
 * memory and program memory that answer one cycle after a request, and
 * that the execution unit holds off requests while BUSY is high.
 */
// Operation
// - Bank register bits 1..0 pick bank 0..2, code 3 reserved, rest zero.
// - Resets clear bank, except watchdog expiry while asleep keeps it.
// - Special function area is identical and reachable in every bank.
// - Direct accesses always go to bank 0; other banks only indirectly.
// - No register-to-register move; data passes through working register.
// - Writing jump low byte jumps within the current page only.
// - Writing jump low byte inserts one dummy cycle.
// - Table read fetches word at lookup pointers; high byte to result.
// - Data writes to flags never touch watchdog expiry or sleep flags.
// - Carry set on addition carry or subtraction without borrow.
// - Rotate through carry shifts carry in and out.
// - Nibble flag set on low nibble carry or no nibble borrow.
// - Null flag set when arithmetic or logic result is zero.
// - Signed flag set when carry into and out of msb differ.
// - Sleep flag cleared by power-up or kick, set by sleep.
// - Watchdog flag cleared by power-up, kick or sleep; set by expiry.
// - Flags are never saved automatically on interrupt or call.
// - Flag byte layout: 5 expiry, 4 sleep, 3..0 arithmetic flags.
`timescale 1ns/1ps
`default_nettype none
module cbs_core_regs
    import cbs_pkg::*;
#(
    parameter int PROG_W = PW
)(
    input  wire logic              SYS_CLK,
    input  wire logic              SYS_RST,
    input  wire logic              CHIP_RST,
    input  wire logic              WDT_TIMEOUT,
    input  wire logic              SLEEP_EXEC,
    input  wire logic              KICK_EXEC,
    input  wire cbs_dreq_t         DM_REQ,
    input  wire cbs_alu_req_t      ALU_REQ,
    input  wire logic              TBL_REQ,
    input  wire logic [DW-1:0]     MEM_RDATA,
    input  wire logic [PROG_W-1:0] PROG_DATA,
    output logic [DW-1:0]          RD_DATA,
    output logic                   RD_VALID,
    output logic                   MEM_REQ,
    output logic                   MEM_WE,
    output logic [BW-1:0]          MEM_BANK,
    output logic [DW-1:0]          MEM_ADDR,
    output logic [DW-1:0]          MEM_WDATA,
    output logic [DW-1:0]          WORK_DATA,
    output logic [DW-1:0]          FLAGS,
    output logic [BW-1:0]          BANK_SEL,
    output logic                   BUSY,
    output logic                   DUMMY_CYCLE,
    output logic                   JUMP_LOAD,
    output logic [DW-1:0]          JUMP_ADDR,
    output logic                   PROG_REQ,
    output logic [2*DW-1:0]        PROG_ADDR,
    output logic [DW-1:0]          TBL_LOW,
    output logic                   TBL_DONE
);
    // Access decode
    logic          sfr;
    logic          hit;
    logic          rsvd;
    logic          lwr;
    logic [BW-1:0] eff_bank;
    logic [DW-1:0] lval;

    // Core registers
    logic [BW-1:0] bank_q, bank_d;
    logic [DW-1:0] work_q, work_d;
    logic [DW-1:0] jump_q, jump_d;
    logic [DW-1:0] lpl_q, lpl_d;
    logic [DW-1:0] lph_q, lph_d;
    logic [DW-1:0] lrh_q, lrh_d;
    logic          wdt_q, wdt_d;
    logic          slp_q, slp_d;
    cbs_flags_t    fl_q, fl_d;

    // Access pipeline
    logic          m_req_q, m_req_d;
    logic          m_we_q, m_we_d;
    logic [BW-1:0] m_bank_q, m_bank_d;
    logic [DW-1:0] m_addr_q, m_addr_d;
    logic [DW-1:0] m_wd_q, m_wd_d;
    logic          rd1_q, rd1_d;
    logic          loc1_q, loc1_d;
    logic [DW-1:0] lv1_q, lv1_d;
    logic          rd2_q, rd2_d;
    logic          loc2_q, loc2_d;
    logic [DW-1:0] lv2_q, lv2_d;
    logic [DW-1:0] rdat_q, rdat_d;
    logic          rval_q, rval_d;

    // Sequencer
    cbs_state_t    st_q, st_d;
    logic          jl_q, jl_d;
    logic [DW-1:0] tlow_q, tlow_d;
    logic          tdone_q, tdone_d;

    logic [DW-1:0] alu_res;
    cbs_flags_t    alu_fl;
    cbs_flags_t    alu_upd;

    cbs_alu u_alu (
        .req      (ALU_REQ),
        .carry_in (fl_q.cry),
        .result   (alu_res),
        .flags    (alu_fl),
        .upd      (alu_upd)
    );

    always_comb begin
        sfr = (DM_REQ.addr < SFR_END);
        hit = sfr && (DM_REQ.addr >= A_BANK) && (DM_REQ.addr <= A_FLAGS);
        rsvd = DM_REQ.ind && !sfr && (bank_q == BANK_RSVD);
        // Special area ignores the bank; direct data goes to bank 0
        eff_bank = (DM_REQ.ind && !sfr) ? bank_q : BANK_RST;
        lwr = DM_REQ.req && DM_REQ.we && hit;
        lval = ZERO8;
        unique case (DM_REQ.addr)
            A_BANK:  lval = {{(DW-BW){1'b0}}, bank_q};
            A_WORK:  lval = work_q;
            A_JUMP:  lval = jump_q;
            A_LPL:   lval = lpl_q;
            A_LPH:   lval = lph_q;
            A_LRH:   lval = lrh_q;
            A_FLAGS: lval = FLAGS;
            default: lval = ZERO8;
        endcase
    end

    always_comb begin
        bank_d = bank_q;
        work_d = work_q;
        jump_d = jump_q;
        lpl_d = lpl_q;
        lph_d = lph_q;
        lrh_d = lrh_q;
        wdt_d = wdt_q;
        slp_d = slp_q;
        fl_d = fl_q;
        if (lwr) begin
            unique case (DM_REQ.addr)
                A_BANK:  bank_d = DM_REQ.wdata[BW-1:0];
                A_WORK:  work_d = DM_REQ.wdata;
                A_JUMP:  jump_d = DM_REQ.wdata;
                A_LPL:   lpl_d = DM_REQ.wdata;
                A_LPH:   lph_d = DM_REQ.wdata;
                A_LRH:   lrh_d = DM_REQ.wdata;
                default: ;
            endcase
        end
        // Bank reset: a watchdog expiry while asleep is a wake-up only
        if (CHIP_RST || (WDT_TIMEOUT && !slp_q)) begin
            bank_d = BANK_RST;
        end
        // Besides plain stores, only the ALU result lands in the working register
        if (ALU_REQ.go && ALU_REQ.wr_work) begin
            work_d = alu_res;
        end
        if (st_q == ST_PCAP) begin
            lrh_d = PROG_DATA[PROG_W-1:DW];
        end
        if (ALU_REQ.go) begin
            if (alu_upd.cry) fl_d.cry = alu_fl.cry;
            if (alu_upd.nib) fl_d.nib = alu_fl.nib;
            if (alu_upd.nul) fl_d.nul = alu_fl.nul;
            if (alu_upd.sgn) fl_d.sgn = alu_fl.sgn;
        end
        // Stores to the flag byte reach the arithmetic flags only
        if (lwr && DM_REQ.addr == A_FLAGS) begin
            fl_d.sgn = DM_REQ.wdata[F_SGN];
            fl_d.nul = DM_REQ.wdata[F_NUL];
            fl_d.nib = DM_REQ.wdata[F_NIB];
            fl_d.cry = DM_REQ.wdata[F_CRY];
        end
        // Set wins over clear for both system flags
        if (KICK_EXEC) begin
            slp_d = 1'b0;
        end
        if (SLEEP_EXEC) begin
            slp_d = 1'b1;
        end
        if (KICK_EXEC || SLEEP_EXEC) begin
            wdt_d = 1'b0;
        end
        if (WDT_TIMEOUT) begin
            wdt_d = 1'b1;
        end
    end

    // No stack port exists: flags are never pushed on call or interrupt
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bank_q <= BANK_RST;
            work_q <= ZERO8;
            jump_q <= ZERO8;
            lpl_q <= ZERO8;
            lph_q <= ZERO8;
            lrh_q <= ZERO8;
            wdt_q <= 1'b0;
            slp_q <= 1'b0;
            fl_q <= '0;
        end else begin
            bank_q <= bank_d;
            work_q <= work_d;
            jump_q <= jump_d;
            lpl_q <= lpl_d;
            lph_q <= lph_d;
            lrh_q <= lrh_d;
            wdt_q <= wdt_d;
            slp_q <= slp_d;
            fl_q <= fl_d;
        end
    end

    always_comb begin
        m_req_d = DM_REQ.req && !hit && !rsvd;
        m_we_d = DM_REQ.we;
        m_bank_d = eff_bank;
        m_addr_d = DM_REQ.addr;
        m_wd_d = DM_REQ.wdata;
        rd1_d = DM_REQ.req && !DM_REQ.we;
        loc1_d = hit || rsvd;
        lv1_d = rsvd ? ZERO8 : lval;
        rd2_d = rd1_q;
        loc2_d = loc1_q;
        lv2_d = lv1_q;
        rval_d = rd2_q;
        rdat_d = rdat_q;
        if (rd2_q) begin
            rdat_d = loc2_q ? lv2_q : MEM_RDATA;
        end
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            m_req_q <= 1'b0;
            m_we_q <= 1'b0;
            m_bank_q <= BANK_RST;
            m_addr_q <= ZERO8;
            m_wd_q <= ZERO8;
            rd1_q <= 1'b0;
            loc1_q <= 1'b0;
            lv1_q <= ZERO8;
            rd2_q <= 1'b0;
            loc2_q <= 1'b0;
            lv2_q <= ZERO8;
            rdat_q <= ZERO8;
            rval_q <= 1'b0;
        end else begin
            m_req_q <= m_req_d;
            m_we_q <= m_we_d;
            m_bank_q <= m_bank_d;
            m_addr_q <= m_addr_d;
            m_wd_q <= m_wd_d;
            rd1_q <= rd1_d;
            loc1_q <= loc1_d;
            lv1_q <= lv1_d;
            rd2_q <= rd2_d;
            loc2_q <= loc2_d;
            lv2_q <= lv2_d;
            rdat_q <= rdat_d;
            rval_q <= rval_d;
        end
    end

    always_comb begin
        st_d = st_q;
        jl_d = 1'b0;
        tlow_d = tlow_q;
        tdone_d = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                if (lwr && DM_REQ.addr == A_JUMP) begin
                    st_d = ST_DUMMY;
                    jl_d = 1'b1;
                end else if (TBL_REQ) begin
                    st_d = ST_PREQ;
                end
            end
            ST_DUMMY: begin
                st_d = ST_IDLE;
            end
            ST_PREQ: begin
                st_d = ST_PCAP;
            end
            ST_PCAP: begin
                st_d = ST_IDLE;
                tlow_d = PROG_DATA[DW-1:0];
                tdone_d = 1'b1;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q <= ST_IDLE;
            jl_q <= 1'b0;
            tlow_q <= ZERO8;
            tdone_q <= 1'b0;
        end else begin
            st_q <= st_d;
            jl_q <= jl_d;
            tlow_q <= tlow_d;
            tdone_q <= tdone_d;
        end
    end

    always_comb begin
        RD_DATA = rdat_q;
        RD_VALID = rval_q;
        MEM_REQ = m_req_q;
        MEM_WE = m_we_q;
        MEM_BANK = m_bank_q;
        MEM_ADDR = m_addr_q;
        MEM_WDATA = m_wd_q;
        WORK_DATA = work_q;
        FLAGS = {2'b00, wdt_q, slp_q, fl_q};
        BANK_SEL = bank_q;
        BUSY = (st_q != ST_IDLE);
        DUMMY_CYCLE = (st_q == ST_DUMMY);
        JUMP_LOAD = jl_q;
        JUMP_ADDR = jump_q;
        PROG_REQ = (st_q == ST_PREQ);
        PROG_ADDR = {lph_q, lpl_q};
        TBL_LOW = tlow_q;
        TBL_DONE = tdone_q;
    end

    AST_BANK_READ_HIGH_ZERO: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        DM_REQ.req && !DM_REQ.we && DM_REQ.addr == A_BANK
        |-> ##3 RD_VALID && RD_DATA[DW-1:BW] == '0)
        else $error("bank register read shows nonzero upper bits");

    AST_DIRECT_BANK0: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        DM_REQ.req && !DM_REQ.ind && !hit
        |=> MEM_REQ && MEM_BANK == BANK_RST)
        else $error("direct access did not reach bank 0");

    AST_RSVD_NO_MEM: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        DM_REQ.req && DM_REQ.ind && !sfr && bank_q == BANK_RSVD
        |=> !MEM_REQ)
        else $error("reserved bank access reached memory");

    AST_JUMP_DUMMY: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        lwr && DM_REQ.addr == A_JUMP && !BUSY
        |=> DUMMY_CYCLE && JUMP_LOAD
        && JUMP_ADDR == $past(DM_REQ.wdata) ##1 !DUMMY_CYCLE)
        else $error("jump write did not give exactly one dummy cycle");

    AST_FLAG_WRITE_KEEPS_SYS: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        lwr && DM_REQ.addr == A_FLAGS
        && !WDT_TIMEOUT && !SLEEP_EXEC && !KICK_EXEC
        |=> $stable(FLAGS[F_WDT:F_SLP]))
        else $error("flag store changed a system flag");

    AST_SLEEP_FLAGS: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        SLEEP_EXEC && !WDT_TIMEOUT
        |=> FLAGS[F_SLP] && !FLAGS[F_WDT])
        else $error("sleep did not set sleep flag and clear expiry");

    AST_EXPIRY_SET: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        WDT_TIMEOUT |=> FLAGS[F_WDT])
        else $error("watchdog expiry flag not set");

    AST_ASLEEP_BANK_KEPT: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        WDT_TIMEOUT && FLAGS[F_SLP] && !CHIP_RST
        && !(lwr && DM_REQ.addr == A_BANK)
        |=> $stable(BANK_SEL))
        else $error("bank changed on wake-up expiry");

    AST_TABLE_SEQ: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        TBL_REQ && !BUSY && !lwr
        |=> PROG_REQ ##1 !PROG_REQ ##1 TBL_DONE && !BUSY)
        else $error("table read sequence broken");

    AST_NULL_FLAG: assert property (
        @(posedge SYS_CLK) disable iff (SYS_RST)
        ALU_REQ.go && alu_upd.nul && !(lwr && DM_REQ.addr == A_FLAGS)
        |=> FLAGS[F_NUL] == ($past(alu_res) == ZERO8))
        else $error("null flag does not match result");
endmodule
`default_nettype wire

/* File: tb/cbs_mem_model.sv */
/*
 * Data and program memory behind the core register block.
 * Assumes one-cycle request pulses, answered one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module cbs_mem_model
    import cbs_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          mem_req,
    input  wire logic          mem_we,
    input  wire logic [BW-1:0] mem_bank,
    input  wire logic [DW-1:0] mem_addr,
    input  wire logic [DW-1:0] mem_wdata,
    input  wire logic          prog_req,
    input  wire logic [15:0]   prog_addr,
    output logic      [DW-1:0] mem_rdata,
    output logic      [15:0]   prog_data
);
    logic [DW-1:0] mem [0:1023];
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 8'(i) ^ 8'h3C;
        mem_rdata = 8'h00;
        prog_data = 16'h0000;
    end
    // Idle read lines toggle so stale data never looks like an answer
    always @(posedge clk) begin
        if (mem_req && mem_we) mem[{mem_bank, mem_addr}] <= mem_wdata;
        if (mem_req && !mem_we) mem_rdata <= mem[{mem_bank, mem_addr}];
        else mem_rdata <= ~mem_rdata;
        if (prog_req) prog_data <= {prog_addr[7:0], prog_addr[15:8]} ^ 16'h5AC3;
        else prog_data <= ~prog_data;
    end
endmodule
`default_nettype wire

/* File: tb/core_bank_and_status_regs_tb.sv */
/*
 * Self-checking bench for the core bank and flag register block.
 * Assumes the memory model answers one cycle after each request.
 */
`timescale 1ns/1ps
`default_nettype none
module core_bank_and_status_regs_tb;
    import cbs_pkg::*;
    logic         SYS_CLK, SYS_RST, CHIP_RST, WDT_TIMEOUT, SLEEP_EXEC;
    logic         KICK_EXEC, TBL_REQ, RD_VALID, MEM_REQ, MEM_WE, BUSY;
    logic         DUMMY_CYCLE, JUMP_LOAD, PROG_REQ, TBL_DONE;
    cbs_dreq_t    DM_REQ;
    cbs_alu_req_t ALU_REQ;
    logic [7:0]   MEM_RDATA, RD_DATA, MEM_ADDR, MEM_WDATA, WORK_DATA;
    logic [7:0]   FLAGS, JUMP_ADDR, TBL_LOW, a, b, v, ef, ew, lp, hp;
    logic [7:0]   dk [4];
    logic [1:0]   MEM_BANK, BANK_SEL;
    logic [15:0]  PROG_DATA, PROG_ADDR, pa_seen, pw;
    logic [11:0]  x;
    logic [9:0]   s;
    cbs_op_t      op;
    int           errors, n_tests, n0;
    int           nm = 0;
    integer       seed = 32'h4407e02e;
    // Bank written, pulse, bank expected, {expiry, sleep} expected
    localparam logic [49:0] SEQ = {10'b10_1000_00_00, 10'b01_0100_00_10,
        10'b10_0010_10_01, 10'b10_0100_10_11, 10'b01_0001_01_00};

    cbs_core_regs #(.PROG_W(16)) uut (.SYS_CLK, .SYS_RST, .CHIP_RST,
        .WDT_TIMEOUT, .SLEEP_EXEC, .KICK_EXEC, .DM_REQ, .ALU_REQ, .TBL_REQ,
        .MEM_RDATA, .PROG_DATA, .RD_DATA, .RD_VALID, .MEM_REQ, .MEM_WE,
        .MEM_BANK, .MEM_ADDR, .MEM_WDATA, .WORK_DATA, .FLAGS, .BANK_SEL,
        .BUSY, .DUMMY_CYCLE, .JUMP_LOAD, .JUMP_ADDR, .PROG_REQ, .PROG_ADDR,
        .TBL_LOW, .TBL_DONE);
    cbs_mem_model mdl (.clk(SYS_CLK), .mem_req(MEM_REQ), .mem_we(MEM_WE),
        .mem_bank(MEM_BANK), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
        .prog_req(PROG_REQ), .prog_addr(PROG_ADDR), .mem_rdata(MEM_RDATA),
        .prog_data(PROG_DATA));

    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        if (MEM_REQ === 1'b1) nm <= nm + 1;
        if (PROG_REQ === 1'b1) pa_seen <= PROG_ADDR;
    end

    task automatic summarize;
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic we, ind, input logic [7:0] ad, d);
        for (int i = 0; i < 8 && BUSY !== 1'b0; i++) @(negedge SYS_CLK);
        DM_REQ = '{1'b1, we, ind, ad, d};
        @(negedge SYS_CLK);
        DM_REQ = '0;
        for (int i = 0; i < 6 && !we && RD_VALID !== 1'b1; i++)
            @(negedge SYS_CLK);
    endtask
    task automatic wr(input logic ind, input logic [7:0] ad, d);
        acc(1'b1, ind, ad, d);
    endtask
    task automatic rd(input logic ind, input logic [7:0] ad, e);
        acc(1'b0, ind, ad, 8'h00);
        chk({7'h00, RD_VALID, RD_DATA}, {8'h01, e});
    endtask
    task automatic sys(input logic [3:0] p);
        {CHIP_RST, WDT_TIMEOUT, SLEEP_EXEC, KICK_EXEC} = p;
        @(negedge SYS_CLK);
        {CHIP_RST, WDT_TIMEOUT, SLEEP_EXEC, KICK_EXEC} = 4'h0;
    endtask
    function automatic logic [11:0] alu_exp(cbs_op_t o, logic [7:0] p, q,
                                            logic [3:0] f);
        logic [7:0] bb, r, lo;
        logic [8:0] sm;
        logic [4:0] n;
        logic       ci;
        ci = (o == ALU_SUB);
        bb = ci ? ~q : q;
        sm = {1'b0, p} + {1'b0, bb} + {8'h00, ci};
        n = {1'b0, p[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        lo = {1'b0, p[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
        r = (o == ALU_AND) ? p & q : (o == ALU_OR) ? p | q : p ^ q;
        case (o)
            ALU_ADD, ALU_SUB:
                return {sm[7:0], lo[7] ^ sm[8], sm[7:0] == 8'h00, n[4], sm[8]};
            ALU_RLC: return {p[6:0], f[0], f[3:1], p[7]};
            ALU_RRC: return {f[0], p[7:1], f[3:1], p[0]};
            ALU_PASS: return {p, f};
            default: return {r, f[3], r == 8'h00, f[1:0]};
        endcase
    endfunction

    initial begin
        #300000;
        errors++;
        summarize();
    end

    initial begin
        SYS_RST = 1'b1;
        {CHIP_RST, WDT_TIMEOUT, SLEEP_EXEC, KICK_EXEC, TBL_REQ} = 5'h00;
        DM_REQ = '0;
        ALU_REQ = '0;
        errors = 0;
        n_tests = 0;
        ef = 8'h00;
        repeat (12) @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        chk({6'h00, BANK_SEL, FLAGS}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            v = {6'($random(seed)), 2'(k)};
            wr(1'b0, A_BANK, v);
            chk({14'h0000, BANK_SEL}, {14'h0000, v[1:0]});
            rd(1'b0, A_BANK, {6'h00, v[1:0]});
            rd(1'b1, A_FLAGS, ef);
            dk[k] = 8'($random(seed));
            n0 = nm;
            wr(1'b1, 8'h70, dk[k]);
            rd(1'b1, 8'h70, (k == 3) ? 8'h00 : dk[k]);
            if (k == 3) chk(16'(nm - n0), 16'h0000);
            wr(1'b0, 8'h71, dk[k] ^ 8'hFF);
        end
        wr(1'b0, A_BANK, 8'h00);
        rd(1'b1, 8'h70, dk[0]);
        rd(1'b1, 8'h71, dk[3] ^ 8'hFF);
        for (int k = 4; k >= 0; k--) begin
            s = SEQ[k*10 +: 10];
            wr(1'b0, A_BANK, {6'h00, s[9:8]});
            sys(s[7:4]);
            ef[5:4] = s[1:0];
            chk({6'h00, BANK_SEL, FLAGS}, {6'h00, s[3:2], ef});
            if (k == 1) begin
                wr(1'b0, A_FLAGS, 8'hFF);
                ef[3:0] = 4'hF;
                rd(1'b0, A_FLAGS, ef);
            end
        end
        wr(1'b0, A_FLAGS, 8'h00);
        ef[3:0] = 4'h0;
        ew = 8'h5C;
        wr(1'b0, A_WORK, ew);
        rd(1'b0, A_WORK, ew);
        for (int k = 0; k < 48; k++) begin
            op = cbs_op_t'(8'h01 << (k % 8));
            a = (k < 8) ? 8'h80 : (k < 16) ? 8'h0F : 8'($random(seed));
            b = (k < 8) ? 8'h80 : (k < 16) ? 8'h01 : 8'($random(seed));
            ALU_REQ = '{1'b1, op != ALU_PASS, op, a, b};
            x = alu_exp(op, a, b, ef[3:0]);
            @(negedge SYS_CLK);
            ef[3:0] = x[3:0];
            if (op != ALU_PASS) ew = x[11:4];
            chk({WORK_DATA, FLAGS}, {ew, ef});
        end
        ALU_REQ = '0;
        v = 8'($random(seed));
        wr(1'b0, A_JUMP, v);
        chk({5'h00, JUMP_LOAD, DUMMY_CYCLE, BUSY, JUMP_ADDR}, {8'h07, v});
        @(negedge SYS_CLK);
        chk({13'h0000, JUMP_LOAD, DUMMY_CYCLE, BUSY}, 16'h0000);
        lp = 8'($random(seed));
        hp = 8'($random(seed));
        wr(1'b0, A_LPL, lp);
        wr(1'b0, A_LPH, hp);
        pw = {lp, hp} ^ 16'h5AC3;
        TBL_REQ = 1'b1;
        @(negedge SYS_CLK);
        TBL_REQ = 1'b0;
        for (int i = 0; i < 8 && TBL_DONE !== 1'b1; i++) @(negedge SYS_CLK);
        chk({TBL_DONE, 7'h00, TBL_LOW}, {8'h80, pw[7:0]});
        chk(pa_seen, {hp, lp});
        rd(1'b0, A_LRH, pw[15:8]);
        wr(1'b0, A_BANK, 8'h02);
        SYS_RST = 1'b1;
        @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        @(negedge SYS_CLK);
        chk({6'h00, BANK_SEL, FLAGS}, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
